/* pwmc_regs.svh */
// Register offsets, field positions and reset values of the PWM controller.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef PWMC_REGS_SVH
`define PWMC_REGS_SVH

// ****************************************
// Global registers
// ****************************************
`define PWMC_MR_OFF      12'h000
`define PWMC_ENA_OFF     12'h004
`define PWMC_DIS_OFF     12'h008
`define PWMC_SR_OFF      12'h00C
`define PWMC_IER_OFF     12'h010
`define PWMC_IDR_OFF     12'h014
`define PWMC_IMR_OFF     12'h018
`define PWMC_ISR_OFF     12'h01C

// ****************************************
// Channel registers: page, stride 0x20
// ****************************************
`define PWMC_CH_PAGE     4'h2
`define PWMC_CMR_OFF     5'h00
`define PWMC_DUTY_VALUE_OFF    5'h04
`define PWMC_PERIOD_VALUE_OFF    5'h08
`define PWMC_CCNT_OFF    5'h0C
`define PWMC_CUPD_OFF    5'h10

// ****************************************
// Field positions
// ****************************************
`define PWMC_DIVIDER_A_FACTOR_LSB    0
`define PWMC_DIVIDER_A_SOURCE_SEL_LSB    8
`define PWMC_DIVIDER_B_FACTOR_LSB    16
`define PWMC_DIVIDER_B_SOURCE_SEL_LSB    24
`define PWMC_CSEL_LSB    0
`define PWMC_ALG_BIT     8
`define PWMC_POL_BIT     9
`define PWMC_CPD_BIT     10

// ****************************************
// Clock select codes and reset values
// ****************************************
`define PWMC_SEL_DIVIDED_CLOCK_A    4'hB
`define PWMC_SEL_DIVIDED_CLOCK_B    4'hC
`define PWMC_NPRE        11
`define PWMC_RST_WORD    32'h0000_0000

`endif

/* pwmc_pkg.sv */
// Types shared by the PWM controller.
// Assumes pwmc_regs.svh for numeric constants.
package pwmc_pkg;

    typedef logic [19:0] pwmc_cnt_t;

    // Whole state of the controller
    typedef struct packed {
        logic [7:0]            divider_a_factor;
        logic [7:0]            divider_b_factor;
        logic [3:0]            divider_a_source_sel;
        logic [3:0]            divider_b_source_sel;
        logic [9:0]            pre;
        logic [7:0]            cnta;
        logic [7:0]            cntb;
        logic [6:0]            en;
        logic [6:0]            irq_mask_reg;
        logic [6:0]            irq_status_reg;
        logic [6:0]            dir;
        logic [6:0]            pend;
        logic [6:0]            alg;
        logic [6:0]            pol;
        logic [6:0]            update_target_sel;
        logic [6:0][3:0]       csel;
        logic [6:0][19:0]      cnt;
        logic [6:0][19:0]      prd;
        logic [6:0][19:0]      dty;
        logic [6:0][19:0]      upd;
        logic [6:0]            wave;
        logic                  irq;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } pwmc_state_s;

endpackage

/* pwmc_top.sv */
// Seven-channel PWM controller with APB register access.
// Assumes pclk at 50 MHz, presetn asynchronous active low, APB master outside.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pwmc_regs.svh"

module pwmc_top (
    input  wire logic        pclk,             // Bus and master clock
    input  wire logic        presetn,          // Asynchronous reset, low
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB access phase
    input  wire logic        pwrite,           // APB write
    input  wire logic [11:0] paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic      [31:0] prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB error, unmapped
    output logic      [6:0]  channel_wave_out, // Channel waveforms
    output logic             irq               // Channel interrupt
);
    import pwmc_pkg::*;

    pwmc_state_s s_q;
    pwmc_state_s s_d;

    logic [10:0] pt;
    logic        ta;
    logic        tb;
    logic [6:0]  tick;
    logic [6:0]  eoc;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        chp;
    logic [2:0]  ch;
    logic [4:0]  co;

    // ****************************************
    // Bus decode
    // ****************************************

    // Access edge, channel page and index
    assign acc = psel && penable && s_q.pready;
    assign wr  = acc && pwrite;
    assign rd  = acc && !pwrite;
    assign chp = (paddr[11:8] == `PWMC_CH_PAGE) && (paddr[7:5] != 3'h7);
    assign ch  = paddr[7:5];
    assign co  = paddr[4:0];

    // ****************************************
    // Clock generator
    // ****************************************

    // Prescaler ticks: tick k fires once every 2^k cycles
    always_comb begin
        pt[0] = 1'b1;
        for (int k = 1; k < `PWMC_NPRE; k++) begin
            pt[k] = &(s_q.pre | ~10'((1 << k) - 1));
        end
    end

    // Divider ticks; factor 0 keeps the clock off
    always_comb begin
        ta = 1'b0;
        tb = 1'b0;
        if (s_q.divider_a_source_sel < 4'(`PWMC_NPRE) && s_q.divider_a_factor != 8'h00) begin
            ta = pt[s_q.divider_a_source_sel] && (s_q.cnta == s_q.divider_a_factor - 8'h01);
        end
        if (s_q.divider_b_source_sel < 4'(`PWMC_NPRE) && s_q.divider_b_factor != 8'h00) begin
            tb = pt[s_q.divider_b_source_sel] && (s_q.cntb == s_q.divider_b_factor - 8'h01);
        end
    end

    // Channel clock selection among thirteen clocks
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (s_q.csel[i] < 4'(`PWMC_NPRE)) begin
                tick[i] = pt[s_q.csel[i]];
            end else if (s_q.csel[i] == `PWMC_SEL_DIVIDED_CLOCK_A) begin
                tick[i] = ta;
            end else if (s_q.csel[i] == `PWMC_SEL_DIVIDED_CLOCK_B) begin
                tick[i] = tb;
            end else begin
                tick[i] = 1'b0;
            end
        end
    end

    // ****************************************
    // Next state
    // ****************************************

    // Clock generator, channels, registers and bus answer
    always_comb begin
        s_d = s_q;
        eoc = 7'h00;

        // Free-running prescaler, divider counters on their source
        s_d.pre = s_q.pre + 10'h001;
        if (s_q.divider_a_source_sel < 4'(`PWMC_NPRE) && pt[s_q.divider_a_source_sel]) begin
            s_d.cnta = ta ? 8'h00 : s_q.cnta + 8'h01;
        end
        if (s_q.divider_b_source_sel < 4'(`PWMC_NPRE) && pt[s_q.divider_b_source_sel]) begin
            s_d.cntb = tb ? 8'h00 : s_q.cntb + 8'h01;
        end
        if (s_q.divider_a_factor == 8'h00) begin
            s_d.cnta = 8'h00;
        end
        if (s_q.divider_b_factor == 8'h00) begin
            s_d.cntb = 8'h00;
        end

        // Channel counters and period end
        for (int i = 0; i < 7; i++) begin
            if (!s_q.en[i]) begin
                s_d.cnt[i] = 20'h00000;
                s_d.dir[i] = 1'b1;
            end else if (tick[i]) begin
                if (!s_q.alg[i]) begin
                    if (s_q.cnt[i] + 20'h00001 >= s_q.prd[i]) begin
                        s_d.cnt[i] = 20'h00000;
                        eoc[i]     = 1'b1;
                    end else begin
                        s_d.cnt[i] = s_q.cnt[i] + 20'h00001;
                    end
                end else if (s_q.dir[i]) begin
                    if (s_q.cnt[i] >= s_q.prd[i]) begin
                        s_d.dir[i] = 1'b0;
                        if (s_q.cnt[i] != 20'h00000) begin
                            s_d.cnt[i] = s_q.cnt[i] - 20'h00001;
                        end
                    end else begin
                        s_d.cnt[i] = s_q.cnt[i] + 20'h00001;
                    end
                end else if (s_q.cnt[i] == 20'h00000) begin
                    eoc[i]     = 1'b1;
                    s_d.dir[i] = 1'b1;
                    s_d.cnt[i] = {19'h00000, s_q.prd[i] != 20'h00000};
                end else begin
                    s_d.cnt[i] = s_q.cnt[i] - 20'h00001;
                end
            end

            // Buffered update taken at period end
            if (eoc[i] && s_q.pend[i]) begin
                s_d.pend[i] = 1'b0;
                if (s_q.update_target_sel[i]) begin
                    s_d.prd[i] = s_q.upd[i];
                end else begin
                    s_d.dty[i] = s_q.upd[i];
                end
            end

            // Comparator
            if (!s_q.en[i]) begin
                s_d.wave[i] = s_q.pol[i];
            end else if (s_q.dty[i] == s_q.prd[i]) begin
                s_d.wave[i] = s_q.pol[i];
            end else if (s_q.dty[i] == 20'h00000) begin
                s_d.wave[i] = !s_q.pol[i];
            end else begin
                s_d.wave[i] = (s_q.cnt[i] >= s_q.dty[i]) ^ s_q.pol[i];
            end
        end

        // Register writes
        if (wr) begin
            unique case (paddr)
                `PWMC_MR_OFF: begin
                    s_d.divider_a_factor = pwdata[`PWMC_DIVIDER_A_FACTOR_LSB +: 8];
                    s_d.divider_a_source_sel = pwdata[`PWMC_DIVIDER_A_SOURCE_SEL_LSB +: 4];
                    s_d.divider_b_factor = pwdata[`PWMC_DIVIDER_B_FACTOR_LSB +: 8];
                    s_d.divider_b_source_sel = pwdata[`PWMC_DIVIDER_B_SOURCE_SEL_LSB +: 4];
                end
                `PWMC_ENA_OFF: s_d.en  = s_q.en | pwdata[6:0];
                `PWMC_DIS_OFF: s_d.en  = s_q.en & ~pwdata[6:0];
                `PWMC_IER_OFF: s_d.irq_mask_reg = s_q.irq_mask_reg | pwdata[6:0];
                `PWMC_IDR_OFF: s_d.irq_mask_reg = s_q.irq_mask_reg & ~pwdata[6:0];
                default: begin
                    if (chp) begin
                        unique case (co)
                            `PWMC_CMR_OFF: begin
                                s_d.csel[ch] = pwdata[`PWMC_CSEL_LSB +: 4];
                                s_d.update_target_sel[ch]  = pwdata[`PWMC_CPD_BIT];
                                if (!s_q.en[ch]) begin
                                    s_d.alg[ch] = pwdata[`PWMC_ALG_BIT];
                                    s_d.pol[ch] = pwdata[`PWMC_POL_BIT];
                                end
                            end
                            `PWMC_DUTY_VALUE_OFF: s_d.dty[ch] = pwdata[19:0];
                            `PWMC_PERIOD_VALUE_OFF: s_d.prd[ch] = pwdata[19:0];
                            `PWMC_CUPD_OFF: begin
                                s_d.upd[ch]  = pwdata[19:0];
                                s_d.pend[ch] = 1'b1;
                            end
                            default: ;
                        endcase
                    end
                end
            endcase
        end

        // Sticky period flags, cleared by reading; a new set wins
        if (rd && paddr == `PWMC_ISR_OFF) begin
            s_d.irq_status_reg = 7'h00;
        end
        s_d.irq_status_reg = s_d.irq_status_reg | eoc;
        s_d.irq = |(s_d.irq_status_reg & s_d.irq_mask_reg);

        // Answer in the access cycle following setup
        s_d.pready  = psel && !penable;
        s_d.pslverr = 1'b0;
        s_d.prdata  = `PWMC_RST_WORD;
        if (psel && !penable) begin
            unique case (paddr)
                `PWMC_MR_OFF: begin
                    s_d.prdata[`PWMC_DIVIDER_A_FACTOR_LSB +: 8] = s_q.divider_a_factor;
                    s_d.prdata[`PWMC_DIVIDER_A_SOURCE_SEL_LSB +: 4] = s_q.divider_a_source_sel;
                    s_d.prdata[`PWMC_DIVIDER_B_FACTOR_LSB +: 8] = s_q.divider_b_factor;
                    s_d.prdata[`PWMC_DIVIDER_B_SOURCE_SEL_LSB +: 4] = s_q.divider_b_source_sel;
                end
                `PWMC_ENA_OFF, `PWMC_DIS_OFF, `PWMC_IER_OFF, `PWMC_IDR_OFF: ;
                `PWMC_SR_OFF:  s_d.prdata[6:0] = s_q.en;
                `PWMC_IMR_OFF: s_d.prdata[6:0] = s_q.irq_mask_reg;
                `PWMC_ISR_OFF: s_d.prdata[6:0] = s_q.irq_status_reg;
                default: begin
                    if (chp && co == `PWMC_CMR_OFF) begin
                        s_d.prdata[`PWMC_CSEL_LSB +: 4] = s_q.csel[ch];
                        s_d.prdata[`PWMC_ALG_BIT]       = s_q.alg[ch];
                        s_d.prdata[`PWMC_POL_BIT]       = s_q.pol[ch];
                        s_d.prdata[`PWMC_CPD_BIT]       = s_q.update_target_sel[ch];
                    end else if (chp && co == `PWMC_DUTY_VALUE_OFF) begin
                        s_d.prdata[19:0] = s_q.dty[ch];
                    end else if (chp && co == `PWMC_PERIOD_VALUE_OFF) begin
                        s_d.prdata[19:0] = s_q.prd[ch];
                    end else if (chp && co == `PWMC_CCNT_OFF) begin
                        s_d.prdata[19:0] = s_q.cnt[ch];
                    end else if (!(chp && co == `PWMC_CUPD_OFF)) begin
                        s_d.pslverr = 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************

    // All state, cleared by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata           = s_q.prdata;
    assign pready           = s_q.pready;
    assign pslverr          = s_q.pslverr;
    assign channel_wave_out = s_q.wave;
    assign irq              = s_q.irq;

    // ****************************************
    // Checks
    // ****************************************

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_period_flag: assert property (eoc[0] |=> s_q.irq_status_reg[0])
        else $error("period end did not set flag");
    a_irq_gated: assert property ((s_d.irq_status_reg & s_d.irq_mask_reg) == 7'h00 |=> !irq)
        else $error("irq without enabled flag");
    a_idle_wave: assert property (!s_q.en[0] |=> channel_wave_out[0] == $past(s_q.pol[0]))
        else $error("disabled output not at polarity");
    a_left_wrap: assert property (s_q.en[0] && !s_q.alg[0] && eoc[0] |=> s_q.cnt[0] == 20'h00000)
        else $error("left counter did not wrap");
    a_divided_clock_a_off: assert property (s_q.divider_a_factor == 8'h00 |-> !ta)
        else $error("clock A runs with factor zero");
    a_pol_lock: assert property (s_q.en[0] |=> s_q.pol[0] == $past(s_q.pol[0]))
        else $error("polarity changed while enabled");

endmodule

/* tb.sv */
// Self-checking bench for the seven-channel PWM controller.
// Assumes pwmc_top and pwmc_regs.svh; the bench itself is the APB master.
`timescale 1ns/1ps
`include "pwmc_regs.svh"

module tb;
    // ****************************************
    // Signals and bookkeeping
    // ****************************************
    typedef struct {logic [31:0] val; logic [31:0] msk; logic err;} pwmc_exp_s;
    logic        pclk         = 1'b0;
    logic        presetn      = 1'b0;
    logic        psel         = 1'b0;
    logic        penable      = 1'b0;
    logic        pwrite       = 1'b0;
    logic [11:0] paddr        = 12'h000;
    logic [31:0] pwdata       = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [6:0]  channel_wave_out;
    logic        irq;
    pwmc_exp_s   exp_q[$];
    pwmc_exp_s   got_e;
    int          failures     = 0;
    int          total_checks = 0;
    int          seed         = 32'h33f6d8ac;
    int          hi;
    int          rises;
    int          d;

    // 50 MHz clock
    always #10 pclk = ~pclk;

    pwmc_top i_dut (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .channel_wave_out (channel_wave_out),
        .irq              (irq)
    );

    // ****************************************
    // Helpers
    // ****************************************
    // Compare and count
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    // Counts, verdict and end of run
    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; the expected answer is queued for the monitor
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] ev, input logic [31:0] em, input logic ee);
        int n;
        exp_q.push_back('{ev, em, ee});
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            failures++;
            $display("CHECK FAILED pready expected 1 seen 0");
            conclude();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ev);
        apb(1'b0, a, 32'h0, ev, 32'hFFFF_FFFF, 1'b0);
    endtask

    function automatic logic [11:0] ca(input int ch, input logic [4:0] off);
        return {`PWMC_CH_PAGE, 3'(ch), off};
    endfunction

    function automatic logic [31:0] cmr(input int cs, input logic alg, input logic pol,
                                        input logic update_target_sel);
        return {21'h0, update_target_sel, pol, alg, 4'h0, 4'(cs)};
    endfunction

    // High samples and rising edges of one channel over n cycles
    task automatic measure(input int ch, input int n);
        logic last;
        hi    = 0;
        rises = 0;
        last  = channel_wave_out[ch];
        repeat (n) begin
            @(posedge pclk);
            if (channel_wave_out[ch] === 1'b1) hi++;
            if (channel_wave_out[ch] === 1'b1 && last === 1'b0) rises++;
            last = channel_wave_out[ch];
        end
    endtask

    // ****************************************
    // Answer monitor
    // ****************************************
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unrequested answer", 32'h0, 32'h1);
            end else begin
                got_e = exp_q.pop_front();
                chk("prdata", got_e.val, prdata & got_e.msk);
                chk("pslverr", {31'h0, got_e.err}, {31'h0, pslverr});
            end
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk("waves after reset", 32'h0, {25'h0, channel_wave_out});
        rd(`PWMC_MR_OFF, 32'h0);
        rd(`PWMC_SR_OFF, 32'h0);
        rd(`PWMC_IMR_OFF, 32'h0);
        for (int c = 0; c < 7; c++) begin
            rd(ca(c, `PWMC_CMR_OFF), 32'h0);
            rd(ca(c, `PWMC_CCNT_OFF), 32'h0);
        end
        apb(1'b0, 12'h100, 32'h0, 32'h0, 32'h0, 1'b1);
        rd(`PWMC_ENA_OFF, 32'h0);
        d = $random(seed);
        wr(`PWMC_MR_OFF, d);
        rd(`PWMC_MR_OFF, d & 32'h0FFF_0FFF);
        // Clock A: source /2, factor 3; clock B stopped
        wr(`PWMC_MR_OFF, 32'h0200_0103);
        d = 1 + ({$random(seed)} % 9);
        wr(ca(0, `PWMC_PERIOD_VALUE_OFF), 32'd10);
        wr(ca(0, `PWMC_DUTY_VALUE_OFF), d);
        wr(ca(1, `PWMC_CMR_OFF), cmr(0, 1'b1, 1'b0, 1'b0));
        wr(ca(1, `PWMC_PERIOD_VALUE_OFF), 32'd10);
        wr(ca(1, `PWMC_DUTY_VALUE_OFF), 32'd4);
        for (int c = 3; c < 5; c++) begin
            wr(ca(c, `PWMC_CMR_OFF), cmr(8 + c, 1'b0, 1'b0, 1'b0));
            wr(ca(c, `PWMC_PERIOD_VALUE_OFF), 32'd2);
            wr(ca(c, `PWMC_DUTY_VALUE_OFF), 32'd1);
        end
        wr(`PWMC_ENA_OFF, 32'h1B);
        rd(`PWMC_SR_OFF, 32'h1B);
        repeat (40) @(posedge pclk);
        measure(0, 100);
        chk("left high", 10 * (10 - d), hi);
        chk("left periods", 32'd10, rises);
        measure(1, 200);
        chk("centre high", 32'd130, hi);
        chk("centre periods", 32'd10, rises);
        measure(3, 240);
        chk("clock A periods", 32'd20, rises);
        measure(4, 60);
        chk("clock B periods", 32'd0, rises);
        rd(ca(4, `PWMC_CCNT_OFF), 32'h0);
        // Buffered duty change on channel 0
        wr(ca(0, `PWMC_CUPD_OFF), 32'd2);
        repeat (30) @(posedge pclk);
        measure(0, 100);
        chk("updated high", 32'd80, hi);
        rd(ca(0, `PWMC_DUTY_VALUE_OFF), 32'd2);
        // Period-end flag, mask and read clear
        wr(`PWMC_IER_OFF, 32'h01);
        rd(`PWMC_IMR_OFF, 32'h01);
        repeat (12) @(posedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b0, `PWMC_ISR_OFF, 32'h0, 32'h1, 32'h1, 1'b0);
        wr(`PWMC_IDR_OFF, 32'h01);
        rd(`PWMC_IMR_OFF, 32'h0);
        wr(`PWMC_DIS_OFF, 32'h7F);
        rd(`PWMC_SR_OFF, 32'h0);
        apb(1'b0, `PWMC_ISR_OFF, 32'h0, 32'h0, 32'h0, 1'b0);
        rd(`PWMC_ISR_OFF, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Every prescaler tap on channel 2, polarity high
        wr(ca(2, `PWMC_PERIOD_VALUE_OFF), 32'd2);
        wr(ca(2, `PWMC_DUTY_VALUE_OFF), 32'd1);
        for (int k = 0; k < `PWMC_NPRE; k++) begin
            wr(`PWMC_DIS_OFF, 32'h04);
            wr(ca(2, `PWMC_CMR_OFF), cmr(k, 1'b0, 1'b1, 1'b0));
            wr(`PWMC_ENA_OFF, 32'h04);
            repeat ((2 << k) + 8) @(posedge pclk);
            measure(2, (2 << k) * 4);
            chk("prescaled periods", 32'd4, rises);
            chk("prescaled high", (2 << k) * 2, hi);
        end
        // Fixed levels and polarity on channel 5
        wr(ca(5, `PWMC_PERIOD_VALUE_OFF), 32'd6);
        for (int i = 0; i < 4; i++) begin
            wr(`PWMC_DIS_OFF, 32'h20);
            wr(ca(5, `PWMC_CMR_OFF), cmr(0, 1'b0, i[1], 1'b0));
            repeat (3) @(posedge pclk);
            chk("idle level", {31'h0, i[1]}, {31'h0, channel_wave_out[5]});
            wr(ca(5, `PWMC_DUTY_VALUE_OFF), i[0] ? 32'd6 : 32'd0);
            wr(`PWMC_ENA_OFF, 32'h20);
            repeat (20) @(posedge pclk);
            measure(5, 40);
            chk("fixed level", (i[0] == i[1]) ? 32'd40 : 32'd0, hi);
        end
        wr(ca(5, `PWMC_CMR_OFF), cmr(0, 1'b1, 1'b0, 1'b0));
        rd(ca(5, `PWMC_CMR_OFF), cmr(0, 1'b0, 1'b1, 1'b0));
        measure(5, 40);
        chk("level kept", 32'd40, hi);
        conclude();
    end
endmodule
